// [core/rwc_top.sv]
// reset and sleep wake-up controller
`timescale 1ns/1ps
module rwc_top
  import rwc_pkg::*;
#(
  parameter logic [CNT_W-1:0] STARTUP_CYCLES = CNT_W'(STARTUP_WAIT_CYCLES)
)
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              reset_pin_n,
  input  wire logic              watchdog_timer_en,
  input  wire logic              watchdog_timer_timeout,
  input  wire logic              low_voltage_reset_en,
  input  wire logic              low_voltage_reset_trip,
  input  wire logic              soft_reset_instr,
  input  wire logic              sleep_instruction,
  input  wire logic              idle_select,
  input  wire logic              green_mode,
  input  wire logic              global_int_enable_instr,
  input  wire logic              global_int_disable_instr,
  input  rwc_osc_t               osc_mode,
  input  wire logic              rc_long_extra,
  input  wire logic              sub_clock_tick,
  input  wire logic [PC_W-1:0]   int_vector,
  input  rwc_wake_en_t           wake_en,
  input  rwc_events_t            events,
  output logic                   core_reset_ff,
  output logic                   osc_run_ff,
  output logic                   pc_clear_ff,
  output logic                   port_dir_in_ff,
  output logic                   watchdog_clear_ff,
  output logic                   power_down_ff,
  output logic                   timeout_flag_ff,
  output logic                   pd_flag_ff,
  output logic                   vector_take_ff,
  output logic [PC_W-1:0]        vector_addr_ff,
  output logic                   resume_next_ff,
  output rwc_pmode_t             pmode_ff
);

  // ****************************************
  // pin synchronisation
  // ****************************************
  logic pin_n_sync;
  rwc_sync2 u_pin_sync (
    .clock (clock),
    .rst   (rst),
    .din   (reset_pin_n),
    .dout  (pin_n_sync)
  );

  // ****************************************
  // reset source decode
  // ****************************************
  logic       gie_ff;
  logic       wdt_at_sleep_ff;
  logic       por_ff;
  rwc_state_t state_ff;
  rwc_state_t nxt_state;
  logic       pin_rst;
  logic       wdt_rst;
  logic       lvr_rst;
  logic       any_rst;
  logic       sleeping;
  logic       in_idle;
  assign pin_rst = !pin_n_sync;
  assign wdt_rst = watchdog_timer_en && watchdog_timer_timeout;
  assign lvr_rst = low_voltage_reset_en && low_voltage_reset_trip;
  assign any_rst = por_ff || pin_rst || wdt_rst || lvr_rst || soft_reset_instr;
  assign sleeping = (state_ff == RWC_ST_LOW) && (pmode_ff == RWC_PM_SLEEP);
  assign in_idle  = (state_ff == RWC_ST_LOW) && (pmode_ff == RWC_PM_IDLE);

  // ****************************************
  // wake event qualification
  // ****************************************
  logic ext_ok;
  logic sleep_wake;
  logic idle_wake;
  logic nonrst_wake;
  assign ext_ok = wake_en.ext_pin_wake_enable && wake_en.ext_pin_int_enable && events.ext_pin;
  // enabled wake sources; counter overflow from sleep only in counter mode
  assign sleep_wake = ext_ok
    || (wake_en.port_change_wake_enable && events.port_change)
    || (wake_en.spi_slave_wake_enable && events.spi_rx)
    || (wake_en.i2c_slave_wake_enable && events.i2c_rx)
    || (wake_en.conversion_done_wake_enable && events.conv_done)
    || (wake_en.counter_overflow_int_enable && wake_en.counter_mode && events.counter_ovf)
    || (wake_en.aux_timer_int_enable && wake_en.aux_counter_mode && events.aux_timer);
  // pwm, timer-mode aux and watch timer reach idle only
  assign idle_wake = sleep_wake
    || (wake_en.counter_overflow_int_enable && events.counter_ovf)
    || (wake_en.pwm_period_match_int_enable && events.pwm_period)
    || (wake_en.pwm_duty_match_int_enable && events.pwm_duty)
    || (wake_en.aux_timer_int_enable && events.aux_timer)
    || (wake_en.watch_timer_int_enable && events.watch_timer);
  // watchdog on at sleep entry blocks peripheral wakes
  assign nonrst_wake = !wdt_at_sleep_ff && ((sleeping && sleep_wake) || (in_idle && idle_wake));

  logic run_int;
  assign run_int = (state_ff == RWC_ST_RUN) && (idle_wake || events.ext_pin && wake_en.ext_pin_int_enable);

  // ****************************************
  // delay selection
  // ****************************************
  function automatic logic [CNT_W-1:0] hold_len(input rwc_osc_t m, input logic rc_long);
    // RC adds 8 or 32; crystal adds 510
    if (m == RWC_OSC_RC)
      hold_len = STARTUP_CYCLES + CNT_W'(rc_long ? EXTRA_RC_LONG : EXTRA_RC_SHORT);
    else
      hold_len = STARTUP_CYCLES + CNT_W'(EXTRA_XTAL);
  endfunction

  logic             dly_load;
  logic             dly_done;
  logic [CNT_W-1:0] dly_val;
  logic             sub_wait_ff;
  logic [9:0]       sub_cnt_ff;
  logic [9:0]       nxt_sub_cnt;
  logic             sub_done;
  logic             sub_hold;
  // low crystal pin or watchdog reset adds sub-clock ticks, not clocks
  assign sub_hold = (osc_mode == RWC_OSC_XTAL_LO) && (pin_rst || wdt_rst);
  assign dly_load = any_rst || (state_ff == RWC_ST_LOW && nonrst_wake);
  assign dly_val  = (!sub_hold && (pin_rst || wdt_rst || state_ff == RWC_ST_LOW))
                    ? hold_len(osc_mode, rc_long_extra) : STARTUP_CYCLES;

  rwc_delay_cnt u_delay (
    .clock    (clock),
    .rst      (rst),
    .load     (dly_load),
    .load_val (dly_val),
    .done     (dly_done)
  );

  // low crystal counts 510 sub-clock ticks after start-up
  assign nxt_sub_cnt = dly_load ? 10'(EXTRA_XTAL)
                     : (dly_done && sub_cnt_ff != '0 && sub_clock_tick) ? sub_cnt_ff - 10'h001 : sub_cnt_ff;
  assign sub_done = !sub_wait_ff || (sub_cnt_ff == '0);

  // ****************************************
  // sequencer
  // ****************************************
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      RWC_ST_RESET: if (!any_rst && dly_done && sub_done) nxt_state = RWC_ST_RUN;
      RWC_ST_RUN:   if (any_rst) nxt_state = RWC_ST_RESET;
                    else if (sleep_instruction) nxt_state = RWC_ST_LOW;
      // pin or watchdog wake is a full reset
      RWC_ST_LOW:   if (any_rst) nxt_state = RWC_ST_RESET;
                    else if (nonrst_wake) nxt_state = RWC_ST_WAKE;
      RWC_ST_WAKE:  if (any_rst) nxt_state = RWC_ST_RESET;
                    else if (dly_done && sub_done) nxt_state = RWC_ST_RUN;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_ff    <= RWC_ST_RESET;
      por_ff      <= 1'b1;
      sub_cnt_ff  <= '0;
      sub_wait_ff <= 1'b0;
    end
    else
    begin
      state_ff    <= nxt_state;
      por_ff      <= 1'b0;
      sub_cnt_ff  <= nxt_sub_cnt;
      sub_wait_ff <= dly_load ? sub_hold : sub_wait_ff;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  logic going_low;
  logic wake_done;
  assign going_low = (state_ff == RWC_ST_RUN) && !any_rst && sleep_instruction;
  assign wake_done = (state_ff == RWC_ST_WAKE) && (nxt_state == RWC_ST_RUN);

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      core_reset_ff     <= 1'b1;
      osc_run_ff        <= 1'b1;
      pc_clear_ff       <= 1'b1;
      port_dir_in_ff    <= 1'b1;
      watchdog_clear_ff <= 1'b1;
      power_down_ff     <= 1'b0;
      timeout_flag_ff   <= 1'b1;
      pd_flag_ff        <= 1'b1;
      gie_ff            <= 1'b0;
      wdt_at_sleep_ff   <= 1'b0;
      vector_take_ff    <= 1'b0;
      vector_addr_ff    <= PC_RESET;
      resume_next_ff    <= 1'b0;
      pmode_ff          <= RWC_PM_NORMAL;
    end
    else
    begin
      core_reset_ff     <= nxt_state == RWC_ST_RESET;
      osc_run_ff        <= !(nxt_state == RWC_ST_LOW && pmode_ff == RWC_PM_SLEEP) || any_rst;
      pc_clear_ff       <= nxt_state == RWC_ST_RESET;
      port_dir_in_ff    <= nxt_state == RWC_ST_RESET;
      // watchdog clear on reset; also on sleep entry
      watchdog_clear_ff <= (nxt_state == RWC_ST_RESET) || going_low;
      power_down_ff     <= (nxt_state == RWC_ST_LOW) && (going_low ? !idle_select : pmode_ff == RWC_PM_SLEEP);
      // timeout and power-down flags record the cause
      if (wdt_rst)
        timeout_flag_ff <= 1'b0;
      else if (pin_rst || por_ff)
        timeout_flag_ff <= 1'b1;
      if (going_low)
        pd_flag_ff <= 1'b0;
      else if (por_ff || (pin_rst && state_ff != RWC_ST_LOW))
        pd_flag_ff <= 1'b1;
      if (nxt_state == RWC_ST_RESET)
        gie_ff <= 1'b0;
      else if (global_int_enable_instr)
        gie_ff <= 1'b1;
      else if (global_int_disable_instr)
        gie_ff <= 1'b0;
      if (going_low)
        wdt_at_sleep_ff <= watchdog_timer_en;
      if (going_low)
        pmode_ff <= idle_select ? RWC_PM_IDLE : RWC_PM_SLEEP;
      else if (wake_done || nxt_state == RWC_ST_RESET)
        pmode_ff <= green_mode ? RWC_PM_GREEN : RWC_PM_NORMAL;
      else if (state_ff == RWC_ST_RUN)
        pmode_ff <= green_mode ? RWC_PM_GREEN : RWC_PM_NORMAL;
      // vector after wake with interrupts on; in run modes
      vector_take_ff    <= gie_ff && (wake_done || run_int);
      // continue after sleep with interrupts off
      resume_next_ff    <= !gie_ff && wake_done;
      if (nxt_state == RWC_ST_RESET)
        vector_addr_ff <= PC_RESET;
      else if (int_vector >= INT_VECTOR_MIN && int_vector <= INT_VECTOR_MAX)
        vector_addr_ff <= int_vector;
      else
        vector_addr_ff <= INT_VECTOR_DEFAULT;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_pin_holds_reset: assert property (@(posedge clock) disable iff (rst)
    !pin_n_sync |=> core_reset_ff)
    else $error("pin low did not hold reset");
  a_reset_pc_clear: assert property (@(posedge clock) disable iff (rst)
    core_reset_ff |-> pc_clear_ff && port_dir_in_ff)
    else $error("reset without pc clear or port input");
  a_reset_wdt_clear: assert property (@(posedge clock) disable iff (rst)
    core_reset_ff |-> watchdog_clear_ff)
    else $error("reset without watchdog clear");
  a_sleep_wdt_clear: assert property (@(posedge clock) disable iff (rst)
    going_low |=> watchdog_clear_ff && !pd_flag_ff)
    else $error("sleep entry missed watchdog clear");
  a_wdt_blocks_wake: assert property (@(posedge clock) disable iff (rst)
    (state_ff == RWC_ST_LOW && wdt_at_sleep_ff && !any_rst) |=> state_ff != RWC_ST_WAKE)
    else $error("peripheral woke with watchdog on");
  a_resume_next: assert property (@(posedge clock) disable iff (rst)
    (wake_done && !gie_ff) |=> resume_next_ff && !vector_take_ff)
    else $error("wake with interrupts off did not resume");
  a_wake_vector: assert property (@(posedge clock) disable iff (rst)
    (wake_done && gie_ff) |=> vector_take_ff)
    else $error("wake with interrupts on missed vector");
  a_reset_hold_min: assert property (@(posedge clock) disable iff (rst)
    $rose(core_reset_ff) |-> core_reset_ff [*8])
    else $error("reset released too early");
  a_osc_in_reset: assert property (@(posedge clock) disable iff (rst)
    core_reset_ff |-> osc_run_ff)
    else $error("oscillator stopped in reset");

endmodule

// [core/rwc_pkg.sv]
// package: constants and types for the reset and wake-up controller
package rwc_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS       = 10;
  localparam int unsigned STARTUP_WAIT_MS     = 16;
  localparam int unsigned STARTUP_WAIT_CYCLES = (STARTUP_WAIT_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned EXTRA_RC_SHORT      = 8;
  localparam int unsigned EXTRA_RC_LONG       = 32;
  localparam int unsigned EXTRA_XTAL          = 510;
  localparam int unsigned CNT_W               = 24;
  localparam int unsigned POR_SYNC_CYCLES     = 2;

  // ****************************************
  // reset values and vectors
  // ****************************************
  localparam int unsigned PC_W        = 12;
  localparam logic [PC_W-1:0] PC_RESET = 12'h000;
  localparam logic [PC_W-1:0] INT_VECTOR_DEFAULT = 12'h004;
  localparam logic [PC_W-1:0] INT_VECTOR_MIN     = 12'h002;
  localparam logic [PC_W-1:0] INT_VECTOR_MAX     = 12'h040;
  localparam int unsigned PORT_W     = 8;
  localparam logic [PORT_W-1:0] PORT_DIR_RESET = 8'hFF;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    RWC_OSC_RC      = 2'h0,
    RWC_OSC_XTAL_HI = 2'h1,
    RWC_OSC_XTAL_LO = 2'h2
  } rwc_osc_t;

  typedef enum logic [1:0] {
    RWC_PM_NORMAL = 2'h0,
    RWC_PM_GREEN  = 2'h1,
    RWC_PM_IDLE   = 2'h2,
    RWC_PM_SLEEP  = 2'h3
  } rwc_pmode_t;

  typedef enum logic [1:0] {
    RWC_ST_RESET = 2'h0,
    RWC_ST_RUN   = 2'h1,
    RWC_ST_LOW   = 2'h2,
    RWC_ST_WAKE  = 2'h3
  } rwc_state_t;

  typedef struct packed {
    logic ext_pin_wake_enable;
    logic ext_pin_int_enable;
    logic port_change_wake_enable;
    logic spi_slave_wake_enable;
    logic i2c_slave_wake_enable;
    logic conversion_done_wake_enable;
    logic counter_overflow_int_enable;
    logic counter_mode;
    logic pwm_period_match_int_enable;
    logic pwm_duty_match_int_enable;
    logic aux_timer_int_enable;
    logic aux_counter_mode;
    logic watch_timer_int_enable;
  } rwc_wake_en_t;

  typedef struct packed {
    logic ext_pin;
    logic port_change;
    logic spi_rx;
    logic i2c_rx;
    logic conv_done;
    logic counter_ovf;
    logic pwm_period;
    logic pwm_duty;
    logic aux_timer;
    logic watch_timer;
  } rwc_events_t;

endpackage

// [core/rwc_sync2.sv]
// two-flop synchroniser for a pin level
`timescale 1ns/1ps
module rwc_sync2
  import rwc_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout
);
  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
    end
    else
    begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;
endmodule

// [core/rwc_delay_cnt.sv]
// down-counter for reset and wake-up hold time
`timescale 1ns/1ps
module rwc_delay_cnt
  import rwc_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_val,
  output logic                  done
);
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;

  assign nxt_cnt = load ? load_val : ((cnt_ff != '0) ? cnt_ff - 24'h000001 : cnt_ff);
  assign done    = (cnt_ff == '0) && !load;

  always_ff @(posedge clock)
  begin
    if (rst)
      cnt_ff <= '0;
    else
      cnt_ff <= nxt_cnt;
  end
endmodule

// [bench/rwc_partner.sv]
// partner model: external reset pin and peripheral event sources
`timescale 1ns/1ps
module rwc_partner
  import rwc_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  pin_low,
  input  wire logic  fire,
  input  rwc_events_t sel,
  output logic        reset_pin_n,
  output rwc_events_t events
);
  // ****************************************
  // pin with pull-up, events one cycle wide
  // ****************************************
  assign reset_pin_n = ~pin_low;
  always @(posedge clock)
  begin
    events <= fire ? rwc_events_t'(sel & (~sel + 10'h1)) : rwc_events_t'(10'h0);
  end
endmodule

// [bench/tb_top.sv]
// self-checking testbench for the reset and wake-up controller
`timescale 1ns/1ps
module tb_top
  import rwc_pkg::*;
;
  localparam int SU    = 20;
  localparam int LIMIT = 20000;
  typedef struct packed {logic [1:0] kind; logic [CNT_W-1:0] val;} rwc_exp_t;
  logic clock = 1'b0, rst = 1'b1, watchdog_timer_en = 1'b0, watchdog_timer_timeout = 1'b0;
  logic low_voltage_reset_en = 1'b1, low_voltage_reset_trip = 1'b0, soft_reset_instr = 1'b0;
  logic sleep_instruction = 1'b0, idle_select = 1'b0, green_mode = 1'b0, rc_long_extra = 1'b0;
  logic global_int_enable_instr = 1'b0, global_int_disable_instr = 1'b0, sub_clock_tick = 1'b1;
  logic pin_low = 1'b0, fire = 1'b0, reset_pin_n;
  logic [PC_W-1:0] int_vector = 12'h004;
  rwc_osc_t osc_mode = RWC_OSC_RC;
  rwc_wake_en_t wake_en = '0;
  rwc_events_t sel = '0, events;
  logic core_reset_ff, osc_run_ff, pc_clear_ff, port_dir_in_ff, watchdog_clear_ff, power_down_ff;
  logic timeout_flag_ff, pd_flag_ff, vector_take_ff, resume_next_ff;
  logic [PC_W-1:0] vector_addr_ff;
  rwc_pmode_t pmode_ff;
  rwc_exp_t exp_q[$];
  int mismatches = 0, tests_run = 0, cycles = 0, hold_cnt = 0;

  rwc_top #(.STARTUP_CYCLES(CNT_W'(SU))) DUT (.clock, .rst, .reset_pin_n, .watchdog_timer_en,
    .watchdog_timer_timeout, .low_voltage_reset_en, .low_voltage_reset_trip, .soft_reset_instr,
    .sleep_instruction, .idle_select, .green_mode, .global_int_enable_instr, .global_int_disable_instr,
    .osc_mode, .rc_long_extra, .sub_clock_tick, .int_vector, .wake_en, .events, .core_reset_ff,
    .osc_run_ff, .pc_clear_ff, .port_dir_in_ff, .watchdog_clear_ff, .power_down_ff, .timeout_flag_ff,
    .pd_flag_ff, .vector_take_ff, .vector_addr_ff, .resume_next_ff, .pmode_ff);
  rwc_partner far_side (.clock, .pin_low, .fire, .sel, .reset_pin_n, .events);

  always #5 clock = ~clock;
  // sub-clock ticks every other cycle so a tick count differs from a clock count
  always @(negedge clock) sub_clock_tick <= ~sub_clock_tick;

  // ****************************************
  // compare tasks and monitor
  // ****************************************
  task automatic fail(input string what, input logic [CNT_W-1:0] e, input logic [CNT_W-1:0] s);
    mismatches++;
    $display("wrong value %s expected %0h seen %0h", what, e, s);
  endtask
  task automatic chk_bit(input string what, input logic e, input logic s);
    tests_run++;
    if (s !== e)
      fail(what, CNT_W'(e), CNT_W'(s));
  endtask
  // hold includes the load edge and, after power-on, the release edge
  task automatic chk_dur(input int e, input int s);
    tests_run++;
    if (s < e || s > e + 2)
      fail("reset hold", CNT_W'(e), CNT_W'(s));
  endtask
  task automatic chk_out(input rwc_exp_t e, input rwc_exp_t s);
    tests_run++;
    if (s !== e)
      fail("wake result", CNT_W'(e), CNT_W'(s));
  endtask
  task automatic take(input rwc_exp_t s);
    rwc_exp_t e;
    if (exp_q.size() == 0)
      fail("unexpected result", '0, CNT_W'(s));
    else
    begin
      e = exp_q.pop_front();
      if (e.kind == 2'h0)
        chk_dur(int'(e.val), int'(s.val));
      else
        chk_out(e, s);
    end
  endtask
  always @(negedge clock)
  begin
    if (rst)
      hold_cnt = 0;
    else if (core_reset_ff === 1'b1)
      hold_cnt++;
    else if (hold_cnt > 0)
    begin
      take('{2'h0, CNT_W'(hold_cnt)});
      hold_cnt = 0;
    end
    if (vector_take_ff === 1'b1)
      take('{2'h1, CNT_W'(vector_addr_ff)});
    if (resume_next_ff === 1'b1)
      take('{2'h2, CNT_W'(0)});
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      mismatches++;
      results();
    end
  end

  // ****************************************
  // stimulus
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic drain();
    for (int i = 0; i < 1200 && exp_q.size() != 0; i++)
      tick(1);
    tick(2);
  endtask
  task automatic reset_by(input int src, input rwc_osc_t m, input logic lng, input int extra);
    osc_mode = m;
    rc_long_extra = lng;
    watchdog_timer_en = (src == 1);
    exp_q.push_back('{2'h0, CNT_W'(SU + extra)});
    case (src)
      0: pin_low = 1'b1;
      1: watchdog_timer_timeout = 1'b1;
      2: low_voltage_reset_trip = 1'b1;
      default: soft_reset_instr = 1'b1;
    endcase
    tick(1);
    {pin_low, watchdog_timer_timeout, low_voltage_reset_trip, soft_reset_instr} = '0;
    watchdog_timer_en = 1'b0;
    tick(4);
    chk_bit("core_reset", 1'b1, core_reset_ff);
    chk_bit("osc_run", 1'b1, osc_run_ff);
    chk_bit("pc_clear", 1'b1, pc_clear_ff);
    chk_bit("port_dir_in", 1'b1, port_dir_in_ff);
    chk_bit("watchdog_clear", 1'b1, watchdog_clear_ff);
    drain();
    if (src == 1)
      chk_bit("timeout_flag", 1'b0, timeout_flag_ff);
    else if (src == 0)
      chk_bit("timeout_flag", 1'b1, timeout_flag_ff);
  endtask
  // md: 0 sleep, 1 idle, 2 stay running
  task automatic run_case(input logic [12:0] en, input logic [9:0] ev, input int md, input logic gie,
                          input logic wdt, input logic ok);
    logic [PC_W-1:0] va;
    int_vector = PC_W'($urandom_range(0, 80));
    va = (int_vector >= 12'h002 && int_vector <= 12'h040) ? int_vector : 12'h004;
    green_mode = 1'($urandom);
    global_int_enable_instr = gie;
    global_int_disable_instr = ~gie;
    tick(1);
    {global_int_enable_instr, global_int_disable_instr} = '0;
    // watchdog off unless the case wants it
    watchdog_timer_en = wdt;
    wake_en = rwc_wake_en_t'(en);
    idle_select = (md == 1);
    if (md != 2)
    begin
      sleep_instruction = 1'b1;
      tick(1);
      sleep_instruction = 1'b0;
      chk_bit("power_down", md == 0, power_down_ff);
      chk_bit("pd_flag", 1'b0, pd_flag_ff);
      chk_bit("pmode_low", 1'b1, pmode_ff === (md == 1 ? RWC_PM_IDLE : RWC_PM_SLEEP));
      if (wdt)
        chk_bit("watchdog_clear", 1'b1, watchdog_clear_ff);
    end
    if (ok)
      exp_q.push_back(gie ? '{2'h1, CNT_W'(va)} : '{2'h2, CNT_W'(0)});
    sel = rwc_events_t'(ev);
    fire = 1'b1;
    tick(1);
    fire = 1'b0;
    tick(40);
    drain();
    chk_bit("power_down", md == 0 && !ok, power_down_ff);
    if (ok)
      chk_bit("pmode_run", 1'b1, pmode_ff === (green_mode ? RWC_PM_GREEN : RWC_PM_NORMAL));
    watchdog_timer_en = 1'b0;
    if (!ok && md == 0)
      reset_by(0, RWC_OSC_RC, 1'b0, 8);
  endtask
  task automatic results();
    if (mismatches == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    void'($urandom(62));
    exp_q.push_back('{2'h0, CNT_W'(SU)});
    tick(3);
    rst = 1'b0;
    drain();
    reset_by(0, RWC_OSC_RC, 1'b0, 8);
    reset_by(1, RWC_OSC_RC, 1'b1, 32);
    reset_by(0, RWC_OSC_XTAL_HI, 1'b0, 510);
    reset_by(1, RWC_OSC_XTAL_LO, 1'b0, 1020);
    reset_by(2, RWC_OSC_RC, 1'b0, 0);
    reset_by(3, RWC_OSC_RC, 1'b1, 0);
    run_case(13'h1800, 10'h200, 0, 1'b1, 1'b0, 1'b1);
    run_case(13'h1800, 10'h200, 1, 1'b0, 1'b0, 1'b1);
    run_case(13'h1000, 10'h200, 0, 1'b1, 1'b0, 1'b0);
    run_case(13'h0400, 10'h100, 0, 1'b0, 1'b0, 1'b1);
    run_case(13'h0200, 10'h080, 0, 1'b1, 1'b0, 1'b1);
    run_case(13'h0100, 10'h040, 0, 1'b0, 1'b0, 1'b1);
    run_case(13'h0080, 10'h020, 0, 1'b1, 1'b0, 1'b1);
    run_case(13'h0060, 10'h010, 0, 1'b0, 1'b0, 1'b1);
    run_case(13'h0040, 10'h010, 0, 1'b1, 1'b0, 1'b0);
    run_case(13'h0040, 10'h010, 1, 1'b1, 1'b0, 1'b1);
    run_case(13'h0010, 10'h008, 0, 1'b1, 1'b0, 1'b0);
    run_case(13'h0008, 10'h004, 1, 1'b0, 1'b0, 1'b1);
    run_case(13'h0004, 10'h002, 0, 1'b1, 1'b0, 1'b0);
    run_case(13'h0006, 10'h002, 0, 1'b1, 1'b0, 1'b1);
    run_case(13'h0001, 10'h001, 0, 1'b0, 1'b0, 1'b0);
    run_case(13'h0001, 10'h001, 1, 1'b1, 1'b0, 1'b1);
    run_case(13'h0400, 10'h100, 0, 1'b1, 1'b1, 1'b0);
    run_case(13'h0040, 10'h010, 2, 1'b1, 1'b0, 1'b1);
    chk_bit("results pending", 1'b0, exp_q.size() != 0);
    results();
  end
endmodule
